// >>> rtl/acc_buf2.sv
// two-entry valid/ready buffer for conversion results
`timescale 1ns/100ps
module acc_buf2 #(
	parameter int W = 10,
	parameter int DEPTH = 2
) (
	input wire logic pclk,
	input wire logic presetn,
	acc_res_if.snk in_s,
	acc_res_if.src out_s
);
	logic [W-1:0] mem_reg [DEPTH];
	logic [$clog2(DEPTH)-1:0] wr_reg, rd_reg;
	logic [$clog2(DEPTH):0] cnt_reg;
	logic push, pop;
	assign in_s.ready = (cnt_reg != DEPTH[$clog2(DEPTH):0]);
	assign out_s.valid = (cnt_reg != '0);
	assign out_s.data = mem_reg[rd_reg];
	assign push = in_s.valid && in_s.ready;
	assign pop = out_s.valid && out_s.ready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push)
				wr_reg <= wr_reg + 1'b1;
			if (pop)
				rd_reg <= rd_reg + 1'b1;
			cnt_reg <= cnt_reg + {{$clog2(DEPTH){1'b0}}, push}
				- {{$clog2(DEPTH){1'b0}}, pop};
		end
	end
	always_ff @(posedge pclk) begin
		if (push)
			mem_reg[wr_reg] <= in_s.data;
	end
	no_overflow_a: assert property (@(posedge pclk) disable iff (!presetn)
		cnt_reg <= DEPTH) else $error("buffer count overflow");
endmodule

// >>> rtl/acc_ctrl.sv
// conversion control top: APB registers, trigger, window, result
`timescale 1ns/100ps
`include "acc_params.svh"
module acc_ctrl #(
	parameter int RES_W = 10,
	parameter int CONV_CYC = `ACC_CONV_CYC
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [3:0] tmr_ovf,
	input wire logic ext_start,
	output logic adc_start,
	output logic adc_pwr_on,
	output logic [4:0] mux_pos,
	output logic [4:0] mux_neg,
	input wire logic adc_done,
	input wire logic [RES_W-1:0] adc_result,
	output logic irq_done,
	output logic irq_win
);
	logic [7:0] ctrl_reg;
	logic [4:0] pos_reg, neg_reg;
	logic [RES_W-1:0] wlo_reg, whi_reg;
	logic done_reg, win_reg;
	logic [RES_W-1:0] data_reg;
	logic sw_go_reg;
	logic ext_s, ext_d_reg;
	logic [15:0] cyc_reg;
	acc_pkg::acc_state_t st_reg;
	logic trig, wr, rd, busy, in_win, hit;
	logic clr_done;
	acc_pkg::acc_trig_t trig_sel;
	acc_res_if #(.W(RES_W)) cap_s ();
	acc_res_if #(.W(RES_W)) out_s ();

	// a write lands once, at the edge where the master sees pready
	assign wr = psel && penable && pwrite && pready;
	assign rd = psel && penable && !pwrite;
	assign busy = (st_reg != acc_pkg::ACC_IDLE);

	acc_sync u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(ext_start),
		.q(ext_s)
	);

	// rising edge only, so a held pin starts one conversion
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ext_d_reg <= 1'b0;
		else
			ext_d_reg <= ext_s;
	end

	assign trig_sel = acc_pkg::acc_trig_t'(
		ctrl_reg[`ACC_CTRL_TRG_HI:`ACC_CTRL_TRG_LO]);
	always_comb begin
		case (trig_sel)
			acc_pkg::ACC_TRG_SW: trig = sw_go_reg;
			acc_pkg::ACC_TRG_T0: trig = tmr_ovf[0];
			acc_pkg::ACC_TRG_T1: trig = tmr_ovf[1];
			acc_pkg::ACC_TRG_T2: trig = tmr_ovf[2];
			acc_pkg::ACC_TRG_T3: trig = tmr_ovf[3];
			acc_pkg::ACC_TRG_EXT: trig = ext_s && !ext_d_reg;
			default: trig = 1'b0;
		endcase
	end

	// software go is a one-cycle pulse from a command write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			sw_go_reg <= 1'b0;
		else
			sw_go_reg <= wr && paddr == `ACC_OFF_CMD
				&& pwdata[`ACC_CMD_START];
	end

	// converter sequence; stalls in DONE if the buffer is full
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg <= acc_pkg::ACC_IDLE;
			cyc_reg <= '0;
		end else begin
			case (st_reg)
				acc_pkg::ACC_IDLE: begin
					// triggers while busy never reach here
					if (trig && ctrl_reg[`ACC_CTRL_EN]) begin
						st_reg <= acc_pkg::ACC_CONV;
						cyc_reg <= '0;
					end
				end
				acc_pkg::ACC_CONV: begin
					cyc_reg <= cyc_reg + 16'h0001;
					if (!ctrl_reg[`ACC_CTRL_EN])
						st_reg <= acc_pkg::ACC_IDLE;
					else if (adc_done)
						st_reg <= acc_pkg::ACC_DONE;
				end
				acc_pkg::ACC_DONE: begin
					if (cap_s.ready)
						st_reg <= acc_pkg::ACC_IDLE;
				end
				default: st_reg <= acc_pkg::ACC_IDLE;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			adc_start <= 1'b0;
		else
			adc_start <= st_reg == acc_pkg::ACC_IDLE && trig
				&& ctrl_reg[`ACC_CTRL_EN];
	end

	// result held from the converter while waiting for buffer room
	logic [RES_W-1:0] hold_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			hold_reg <= '0;
		else if (st_reg == acc_pkg::ACC_CONV && adc_done)
			hold_reg <= adc_result;
	end
	assign cap_s.valid = (st_reg == acc_pkg::ACC_DONE);
	assign cap_s.data = hold_reg;

	acc_buf2 #(.W(RES_W), .DEPTH(2)) u_buf (
		.pclk(pclk),
		.presetn(presetn),
		.in_s(cap_s),
		.out_s(out_s)
	);
	assign out_s.ready = 1'b1;

	assign in_win = out_s.data >= wlo_reg && out_s.data <= whi_reg;
	assign hit = out_s.valid && (in_win ^ ctrl_reg[`ACC_CTRL_WOUT]);
	assign clr_done = wr && paddr == `ACC_OFF_STAT;

	// completion latch: data and flags at the same edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			data_reg <= '0;
		else if (out_s.valid)
			data_reg <= out_s.data;
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
			win_reg <= 1'b0;
		end else begin
			if (out_s.valid)
				done_reg <= 1'b1;
			else if (clr_done && pwdata[`ACC_STAT_DONE])
				done_reg <= 1'b0;
			if (hit)
				win_reg <= 1'b1;
			else if (clr_done && pwdata[`ACC_STAT_WIN])
				win_reg <= 1'b0;
		end
	end

	// background mode silences completion requests
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_done <= 1'b0;
			irq_win <= 1'b0;
		end else begin
			irq_done <= done_reg && ctrl_reg[`ACC_CTRL_IEN]
				&& !ctrl_reg[`ACC_CTRL_BG];
			irq_win <= win_reg && ctrl_reg[`ACC_CTRL_WIEN];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= '0;
			pos_reg <= '0;
			neg_reg <= `ACC_MUX_GND;
			wlo_reg <= '0;
			whi_reg <= `ACC_WHI_RESET;
		end else if (wr) begin
			case (paddr)
				`ACC_OFF_CTRL: ctrl_reg <= pwdata[7:0];
				`ACC_OFF_MUX: begin
					pos_reg <= pwdata[4:0];
					neg_reg <= pwdata[12:8];
				end
				`ACC_OFF_WLO: wlo_reg <= pwdata[RES_W-1:0];
				`ACC_OFF_WHI: whi_reg <= pwdata[RES_W-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			adc_pwr_on <= 1'b0;
			mux_pos <= '0;
			mux_neg <= `ACC_MUX_GND;
		end else begin
			adc_pwr_on <= ctrl_reg[`ACC_CTRL_EN];
			mux_pos <= pos_reg;
			mux_neg <= neg_reg;
		end
	end

	// one wait state: ready in the second access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= '0;
		end else begin
			pready <= psel && penable && !pready;
			pslverr <= 1'b0;
			prdata <= '0;
			if (psel && penable && !pready) begin
				case (paddr)
					`ACC_OFF_CTRL: prdata <= {24'h0, ctrl_reg};
					`ACC_OFF_MUX: prdata <= {19'h0, neg_reg, 3'h0, pos_reg};
					`ACC_OFF_STAT: prdata <= {29'h0, busy, win_reg, done_reg};
					`ACC_OFF_DATA: prdata <= {{(32-RES_W){1'b0}}, data_reg};
					`ACC_OFF_WLO: prdata <= {{(32-RES_W){1'b0}}, wlo_reg};
					`ACC_OFF_WHI: prdata <= {{(32-RES_W){1'b0}}, whi_reg};
					`ACC_OFF_CMD: prdata <= '0;
					default: pslverr <= 1'b1;
				endcase
			end
		end
	end

	logic unused_rd;
	assign unused_rd = rd;

	off_blocks_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		!ctrl_reg[`ACC_CTRL_EN] |=> !adc_start)
		else $error("start while shut down");
	busy_ignore_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		busy |=> !adc_start)
		else $error("start while busy");
	start_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg == acc_pkg::ACC_IDLE && trig && ctrl_reg[`ACC_CTRL_EN]
		|=> adc_start && st_reg == acc_pkg::ACC_CONV)
		else $error("trigger not taken");
	done_set_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		out_s.valid |=> done_reg)
		else $error("done not set");
	data_cap_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		out_s.valid |=> data_reg == $past(out_s.data))
		else $error("result not captured");
	win_set_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		hit |=> win_reg)
		else $error("window flag missed");
	bg_quiet_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		ctrl_reg[`ACC_CTRL_BG] |=> !irq_done)
		else $error("background irq leak");
	mux_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> mux_pos == $past(pos_reg))
		else $error("mux not applied");
	rate_ok_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg == acc_pkg::ACC_DONE && cap_s.ready
		|=> st_reg == acc_pkg::ACC_IDLE)
		else $error("no back to back");
	// a 100 MHz clock and 5 us sample period leave 500 cycles
	conv_time_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg == acc_pkg::ACC_CONV |-> cyc_reg < 16'(CONV_CYC))
		else $error("conversion too slow");
	abort_off_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg == acc_pkg::ACC_CONV && !ctrl_reg[`ACC_CTRL_EN]
		|=> st_reg == acc_pkg::ACC_IDLE)
		else $error("shutdown did not abort");
	pwr_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> adc_pwr_on == $past(ctrl_reg[`ACC_CTRL_EN]))
		else $error("power select not applied");
	neg_follow_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		1'b1 |=> mux_neg == $past(neg_reg))
		else $error("negative select not applied");
	win_irq_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		win_reg && ctrl_reg[`ACC_CTRL_WIEN] |=> irq_win)
		else $error("window request missed");
	done_irq_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		done_reg && ctrl_reg[`ACC_CTRL_IEN] && !ctrl_reg[`ACC_CTRL_BG]
		|=> irq_done)
		else $error("completion request missed");
	clr_done_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		clr_done && pwdata[`ACC_STAT_DONE] && !out_s.valid
		|=> !done_reg)
		else $error("done not cleared");
	hold_cap_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		st_reg == acc_pkg::ACC_CONV && adc_done
		|=> hold_reg == $past(adc_result))
		else $error("converter result not held");
	ext_edge_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		ext_s && !ext_d_reg && trig_sel == acc_pkg::ACC_TRG_EXT
		&& ctrl_reg[`ACC_CTRL_EN] && !busy |=> adc_start)
		else $error("external edge not taken");
	sw_pulse_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		sw_go_reg |=> !sw_go_reg)
		else $error("software start too long");
	start_pulse_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		adc_start |=> !adc_start)
		else $error("start pulse too long");
	rd_data_a: assert property (
		@(posedge pclk) disable iff (!presetn)
		pready && !pwrite && paddr == `ACC_OFF_DATA
		|-> prdata[RES_W-1:0] == $past(data_reg))
		else $error("result read wrong");
	conv_cv: cover property (@(posedge pclk) disable iff (!presetn)
		adc_start ##[1:600] out_s.valid);
	win_cv: cover property (@(posedge pclk) disable iff (!presetn) hit);
	ext_cv: cover property (@(posedge pclk) disable iff (!presetn)
		ext_s && !ext_d_reg && adc_start == 1'b0);
	abort_cv: cover property (@(posedge pclk) disable iff (!presetn)
		st_reg == acc_pkg::ACC_CONV && !ctrl_reg[`ACC_CTRL_EN]);
	bg_win_cv: cover property (@(posedge pclk) disable iff (!presetn)
		hit && ctrl_reg[`ACC_CTRL_BG]);
endmodule

// >>> rtl/acc_params.svh
// constants for the conversion control block
// Operation
// - six selectable conversion start triggers
// - completion sets status, optional interrupt request
// - result captured when conversion completes
// - window compare inside or outside interrupt
// - background mode interrupts only on window
// - sixteen channel positive and negative selects
// - temperature sensor and supply also selectable
// - shutdown setting blocks all conversions
// - back to back conversions up to 200 ksps
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH
`define ACC_OFF_CTRL 12'h000
`define ACC_OFF_MUX 12'h004
`define ACC_OFF_STAT 12'h008
`define ACC_OFF_DATA 12'h00C
`define ACC_OFF_WLO 12'h010
`define ACC_OFF_WHI 12'h014
`define ACC_OFF_CMD 12'h018
`define ACC_CTRL_EN 0
`define ACC_CTRL_IEN 1
`define ACC_CTRL_WIEN 2
`define ACC_CTRL_WOUT 3
`define ACC_CTRL_BG 4
`define ACC_CTRL_TRG_LO 5
`define ACC_CTRL_TRG_HI 7
`define ACC_STAT_DONE 0
`define ACC_STAT_WIN 1
`define ACC_STAT_BUSY 2
`define ACC_CMD_START 0
`define ACC_MUX_TEMP 5'h10
`define ACC_MUX_VDD 5'h11
`define ACC_MUX_GND 5'h1F
`define ACC_WHI_RESET 10'h3FF
`define ACC_SAMPLE_NS 5000
`define ACC_CLK_NS 10
`define ACC_CONV_CYC (`ACC_SAMPLE_NS / `ACC_CLK_NS)
`endif

// >>> rtl/acc_pkg.sv
// types for the conversion control block
package acc_pkg;
	typedef enum logic [2:0] {
		ACC_TRG_SW = 3'h0,
		ACC_TRG_T0 = 3'h1,
		ACC_TRG_T1 = 3'h2,
		ACC_TRG_T2 = 3'h3,
		ACC_TRG_T3 = 3'h4,
		ACC_TRG_EXT = 3'h5
	} acc_trig_t;
	typedef enum logic [1:0] {
		ACC_IDLE = 2'b00,
		ACC_CONV = 2'b01,
		ACC_DONE = 2'b11
	} acc_state_t;
endpackage

// >>> rtl/acc_res_if.sv
// result stream carrier between core and buffer
`timescale 1ns/100ps
interface acc_res_if #(parameter int W = 10);
	logic valid;
	logic ready;
	logic [W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

// >>> rtl/acc_sync.sv
// two-flop synchroniser for the external start pin
`timescale 1ns/100ps
module acc_sync (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic d,
	output logic q
);
	logic s1_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_reg <= d;
			q <= s1_reg;
		end
	end
endmodule

// >>> verification/acc_adc_model.sv
// behavioural converter core answering a start taken while powered and idle with done and a result, unless power drops first
`timescale 1ns/100ps
module acc_adc_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic adc_start,
	input wire logic adc_pwr_on,
	input wire logic [7:0] dly,
	input wire logic [9:0] val,
	output logic adc_done,
	output logic [9:0] adc_result
);
	logic [7:0] cnt;
	logic busy;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy <= 1'h0;
			cnt <= 8'h00;
			adc_done <= 1'h0;
			adc_result <= 10'h000;
		end else begin
			adc_done <= 1'h0;
			// result only good with done; toggling exposes late capture
			adc_result <= ~adc_result;
			if (!adc_pwr_on) begin
				busy <= 1'h0;
			end else if (adc_start && !busy) begin
				busy <= 1'h1;
				cnt <= dly;
			end else if (busy && cnt == 8'h00) begin
				busy <= 1'h0;
				adc_done <= 1'h1;
				adc_result <= val;
			end else if (busy) begin
				cnt <= cnt - 8'h01;
			end
		end
	end
endmodule

// >>> verification/adc_conversion_control_test.sv
// self-checking bench for the conversion control block
`timescale 1ns/100ps
`include "acc_params.svh"
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
	$display("BAD %0t %h not %h", $time, a, b); end end
module adc_conversion_control_test;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic ext_start, adc_start, adc_pwr_on, adc_done, irq_done, irq_win;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, st;
	logic [3:0] tmr_ovf;
	logic [4:0] mux_pos, mux_neg;
	logic [9:0] adc_result, val;
	logic [7:0] dly;
	int n_errors, checks, n_st, n0;
	logic [9:0] wv [5] = '{10'h0FF, 10'h100, 10'h201, 10'h200, 10'h3FF};
	logic we [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h1};
	acc_ctrl i_acc_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.tmr_ovf(tmr_ovf), .ext_start(ext_start), .adc_start(adc_start),
		.adc_pwr_on(adc_pwr_on), .mux_pos(mux_pos), .mux_neg(mux_neg),
		.adc_done(adc_done), .adc_result(adc_result),
		.irq_done(irq_done), .irq_win(irq_win));
	acc_adc_model i_acc_adc_model (.pclk(pclk), .presetn(presetn),
		.adc_start(adc_start), .adc_pwr_on(adc_pwr_on), .dly(dly), .val(val),
		.adc_done(adc_done), .adc_result(adc_result));
	initial begin
		pclk = 1'h0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (adc_start === 1'h1) n_st++;
	end
	initial begin
		#100000;
		n_errors++;
		end_sim();
	end
	task end_sim();
		$display("errors %0d checks %0d", n_errors, checks);
		if (n_errors == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'h1 && n < 20);
		rd = prdata;
		err = pslverr;
		if (n >= 20) n_errors++;
		psel <= 1'h0;
		penable <= 1'h0;
		// two idle edges: registered outputs settle before any check
		@(posedge pclk);
		@(posedge pclk);
	endtask
	task conv(input logic [9:0] v);
		int k;
		apb(1'h1, `ACC_OFF_STAT, 32'h7);
		val <= v;
		apb(1'h1, `ACC_OFF_CMD, 32'h1);
		k = 0;
		do begin
			apb(1'h0, `ACC_OFF_STAT, 32'h0);
			k++;
		end while (rd[`ACC_STAT_DONE] !== 1'h1 && k < 30);
		st = rd;
	endtask
	task pulse(input logic [3:0] m, input logic e);
		tmr_ovf <= m;
		ext_start <= e;
		@(posedge pclk);
		tmr_ovf <= 4'h0;
		ext_start <= 1'h0;
		repeat (12) @(posedge pclk);
	endtask
	task t_reset();
		`CHK(mux_neg, `ACC_MUX_GND)
		`CHK(adc_pwr_on, 1'h0)
		apb(1'h0, `ACC_OFF_WHI, 32'h0);
		`CHK(rd[9:0], `ACC_WHI_RESET)
		apb(1'h0, `ACC_OFF_WLO, 32'h0);
		`CHK(rd[9:0], 10'h000)
		apb(1'h0, 12'h0FC, 32'h0);
		`CHK(err, 1'h1)
	endtask
	task t_mux();
		apb(1'h1, `ACC_OFF_MUX, {19'h0, `ACC_MUX_TEMP, 3'h0, `ACC_MUX_VDD});
		`CHK(mux_pos, `ACC_MUX_VDD)
		`CHK(mux_neg, `ACC_MUX_TEMP)
		apb(1'h1, `ACC_OFF_MUX, 32'h030F);
		`CHK(mux_pos, 5'h0F)
		`CHK(mux_neg, 5'h03)
	endtask
	task t_off();
		n0 = n_st;
		apb(1'h1, `ACC_OFF_CTRL, 32'h0);
		apb(1'h1, `ACC_OFF_CMD, 32'h1);
		repeat (10) @(posedge pclk);
		`CHK(n_st, n0)
		`CHK(adc_pwr_on, 1'h0)
		apb(1'h1, `ACC_OFF_CTRL, 32'h3);
		`CHK(adc_pwr_on, 1'h1)
	endtask
	task t_sw();
		n0 = n_st;
		conv(10'h2A5);
		`CHK(n_st, n0 + 1)
		`CHK(st[`ACC_STAT_DONE], 1'h1)
		`CHK(irq_done, 1'h1)
		apb(1'h0, `ACC_OFF_DATA, 32'h0);
		`CHK(rd[9:0], 10'h2A5)
		apb(1'h1, `ACC_OFF_STAT, 32'h1);
		`CHK(irq_done, 1'h0)
	endtask
	task t_trig();
		logic [3:0] m;
		for (int k = 1; k < 6; k++) begin
			m = (k < 5) ? 4'h1 << (k - 1) : 4'h0;
			apb(1'h1, `ACC_OFF_CTRL, {24'h0, 3'(k), 5'h01});
			n0 = n_st;
			// the other timer and external sources fire first and must be ignored
			pulse(~m, k < 5);
			`CHK(n_st, n0)
			pulse(m, k == 5);
			`CHK(n_st, n0 + 1)
			`CHK(irq_done, 1'h0)
		end
	endtask
	task t_busy();
		apb(1'h1, `ACC_OFF_CTRL, 32'h1);
		dly <= 8'h1E;
		n0 = n_st;
		apb(1'h1, `ACC_OFF_CMD, 32'h1);
		conv(10'h155);
		`CHK(n_st, n0 + 1)
		dly <= 8'h00;
		conv(10'h0AA);
		`CHK(n_st, n0 + 2)
		apb(1'h0, `ACC_OFF_DATA, 32'h0);
		`CHK(rd[9:0], 10'h0AA)
		// shutdown in mid-conversion: no result, no longer busy
		apb(1'h1, `ACC_OFF_STAT, 32'h7);
		dly <= 8'h1E;
		apb(1'h1, `ACC_OFF_CMD, 32'h1);
		apb(1'h1, `ACC_OFF_CTRL, 32'h0);
		repeat (40) @(posedge pclk);
		apb(1'h0, `ACC_OFF_STAT, 32'h0);
		`CHK(rd[2:0], 3'h0)
		`CHK(n_st, n0 + 3)
		dly <= 8'h02;
	endtask
	task t_win();
		apb(1'h1, `ACC_OFF_WLO, 32'h100);
		apb(1'h1, `ACC_OFF_WHI, 32'h200);
		apb(1'h1, `ACC_OFF_CTRL, 32'h17);
		for (int i = 0; i < 5; i++) begin
			if (i == 3) apb(1'h1, `ACC_OFF_CTRL, 32'h1F);
			conv(wv[i]);
			`CHK(st[`ACC_STAT_WIN], we[i])
			`CHK(irq_win, we[i])
			`CHK(irq_done, 1'h0)
		end
	endtask
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		tmr_ovf = 4'h0;
		ext_start = 1'h0;
		val = 10'h000;
		dly = 8'h02;
		repeat (4) @(posedge pclk);
		presetn <= 1'h1;
		@(posedge pclk);
		t_reset();
		t_mux();
		t_off();
		t_sw();
		t_trig();
		t_busy();
		t_win();
		end_sim();
	end
endmodule
